// *** src/serr_pkg.sv ***
package serr_pkg;
	// Register indices on the internal register port
	localparam logic [7:0] ADDR_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_ROUTE = 8'h19;
	localparam logic [7:0] ADDR_SETUP = 8'h1A;
	// Register and field widths
	localparam int REG_W = 16;
	localparam int NUM_CH = 4;
	localparam int NUM_FAULT = 6;
	localparam int RES_ERR_W = 4;
	// Status layout
	localparam int ST_CHAN_HI = 15;
	localparam int ST_CHAN_LO = 14;
	localparam int ST_FAULT_HI = 13;
	localparam int ST_FAULT_LO = 8;
	localparam int ST_READY = 6;
	// Fault vector order: under, over, timeout, amp high, amp low, zero count
	localparam int F_UR = 5;
	localparam int F_OR = 4;
	localparam int F_WD = 3;
	localparam int F_AH = 2;
	localparam int F_AL = 1;
	localparam int F_ZC = 0;
	// Routing register layout
	localparam int RT_UR_OUT = 15;
	localparam int RT_OR_OUT = 14;
	localparam int RT_WD_OUT = 13;
	localparam int RT_AH_OUT = 12;
	localparam int RT_AL_OUT = 11;
	localparam int RT_IRQ_HI = 7;
	localparam int RT_IRQ_LO = 2;
	localparam int RT_READY_IRQ = 0;
	// Bits of the routing register that hold storage
	localparam logic [15:0] ROUTE_MASK = 16'hF8FD;
	// Result error field order inside each channel nibble
	localparam int RE_UR = 3;
	localparam int RE_OR = 2;
	localparam int RE_WD = 1;
	localparam int RE_AE = 0;
	// Setup register
	localparam int SU_IRQ_DIS = 7;
	// Reset values
	localparam logic [15:0] ROUTE_RESET = 16'h0000;
	localparam logic [15:0] SETUP_RESET = 16'h2801;
endpackage : serr_pkg

// *** src/serr_status.sv ***
// Behaviour
// R1: Status 15:14 names faulting channel
// R2: Faults latched until status or source read
// R3: Bit 13 latches under-range fault
// R4: Bit 12 latches over-range fault
// R5: Bit 11 latches watchdog timeout fault
// R6: Bit 10 latches amplitude high fault
// R7: Bit 9 latches amplitude low fault
// R8: Bit 8 latches zero count fault
// R9: Bit 6 flags new results ready
// R10: Reserved status bits 7, 5:4 read zero
// R11: Bits 3:0 flag unread channel results
// R12: Route enables copy faults into result fields
// R13: Both amplitude faults share one field
// R14: Interrupt enables gate fault status and pin
// R15: Bit 0 gates ready status and pin
// R16: Host writes zeros to reserved routing bits
// R17: Setup disable bit holds pin high
// R18: Pin low while enabled condition pending
`timescale 1ns/100ps
module serr_status (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Register port from the serial interface logic
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// Conversion engine events
	input wire logic fault_valid_i,
	input wire logic [1:0] fault_ch_i,
	input wire logic [5:0] fault_type_i,
	input wire logic conv_done_i,
	input wire logic [1:0] conv_ch_i,
	input wire logic ready_event_i,
	// Result register reads
	input wire logic data_rd_i,
	input wire logic [1:0] data_rd_ch_i,
	// Outputs
	output logic [15:0] result_err_o,
	output logic [15:0] main_operating_setup_o,
	output logic irq_pin_n_o
);

	// Latched fault flags, status bits 13:8
	logic [5:0] fault_flags;
	logic [5:0] next_fault_flags;
	// Channel recorded as fault source
	logic [1:0] fault_source_channel;
	logic [1:0] next_fault_source_channel;
	// Data ready flag
	logic result_ready_flag;
	logic next_result_ready_flag;
	// Unread result flags, index is the channel
	logic [3:0] unread;
	logic [3:0] next_unread;
	// Per-channel result error nibbles
	logic [15:0] res_err;
	logic [15:0] next_res_err;
	// Software registers
	logic [15:0] fault_routing_enables;
	logic [15:0] next_fault_routing_enables;
	logic [15:0] main_operating_setup;
	logic [15:0] next_main_operating_setup;
	// Registered outputs
	logic [15:0] next_rdata;
	logic next_irq_n;
	// Decode helpers
	logic status_read;
	logic src_read;
	logic [5:0] fault_hit;

	// Assemble the status word from current state
	function automatic logic [15:0] status_word(input logic [1:0] src, input logic [5:0] f,
			input logic rdy, input logic [3:0] u);
		logic [15:0] w;
		w = 16'h0000;
		w[serr_pkg::ST_CHAN_HI:serr_pkg::ST_CHAN_LO] = src;
		w[serr_pkg::ST_FAULT_HI:serr_pkg::ST_FAULT_LO] = f;
		w[serr_pkg::ST_READY] = rdy;
		// Channel 0 sits in bit 3, channel 3 in bit 0
		w[3:0] = {u[0], u[1], u[2], u[3]};
		return w;
	endfunction : status_word

	// Event decode and next state for all flags
	always_comb begin
		status_read = reg_rd_i && (reg_addr_i == serr_pkg::ADDR_FLAGS);
		src_read = data_rd_i && (data_rd_ch_i == fault_source_channel);
		// R14: gate faults
		fault_hit = fault_valid_i ?
			(fault_type_i & fault_routing_enables[serr_pkg::RT_IRQ_HI:serr_pkg::RT_IRQ_LO]) :
			6'h00;
		// R2: hold until qualifying read
		next_fault_flags = (status_read || src_read) ? 6'h00 : fault_flags;
		// R3 R4 R5 R6 R7 R8: set wins over clear
		// A fault landing on the clearing read must not be lost, so the set goes last
		next_fault_flags = next_fault_flags | fault_hit;
		next_fault_source_channel = fault_source_channel;
		// R1: record source of first pending fault
		if ((fault_hit != 6'h00) && ((fault_flags == 6'h00) || status_read || src_read)) begin
			next_fault_source_channel = fault_ch_i;
		end
		// R9: ready since last status read
		next_result_ready_flag = status_read ? 1'b0 : result_ready_flag;
		// R15: gate ready
		if (ready_event_i && fault_routing_enables[serr_pkg::RT_READY_IRQ]) begin
			next_result_ready_flag = 1'b1;
		end
		// R11: unread results per channel
		next_unread = unread;
		if (data_rd_i) begin
			next_unread[data_rd_ch_i] = 1'b0;
		end
		if (conv_done_i) begin
			next_unread[conv_ch_i] = 1'b1;
		end
		// Result error fields clear when that channel is read
		next_res_err = res_err;
		if (data_rd_i) begin
			next_res_err[data_rd_ch_i * 4 +: 4] = 4'h0;
		end
		// R12: copy routed faults
		if (fault_valid_i) begin
			next_res_err[fault_ch_i * 4 + serr_pkg::RE_UR] = res_err_or(
				fault_type_i[serr_pkg::F_UR] && fault_routing_enables[serr_pkg::RT_UR_OUT],
				next_res_err[fault_ch_i * 4 + serr_pkg::RE_UR]);
			next_res_err[fault_ch_i * 4 + serr_pkg::RE_OR] = res_err_or(
				fault_type_i[serr_pkg::F_OR] && fault_routing_enables[serr_pkg::RT_OR_OUT],
				next_res_err[fault_ch_i * 4 + serr_pkg::RE_OR]);
			next_res_err[fault_ch_i * 4 + serr_pkg::RE_WD] = res_err_or(
				fault_type_i[serr_pkg::F_WD] && fault_routing_enables[serr_pkg::RT_WD_OUT],
				next_res_err[fault_ch_i * 4 + serr_pkg::RE_WD]);
			// R13: shared amplitude field
			next_res_err[fault_ch_i * 4 + serr_pkg::RE_AE] = res_err_or(
				(fault_type_i[serr_pkg::F_AH] && fault_routing_enables[serr_pkg::RT_AH_OUT]) ||
				(fault_type_i[serr_pkg::F_AL] && fault_routing_enables[serr_pkg::RT_AL_OUT]),
				next_res_err[fault_ch_i * 4 + serr_pkg::RE_AE]);
		end
	end

	// Set-wins merge of one result error bit
	function automatic logic res_err_or(input logic set, input logic cur);
		return set | cur;
	endfunction : res_err_or

	// Register writes; reserved routing bits are not stored, so a careless host
	// write there cannot leak into the read-back
	always_comb begin
		next_fault_routing_enables = fault_routing_enables;
		next_main_operating_setup = main_operating_setup;
		if (reg_wr_i && (reg_addr_i == serr_pkg::ADDR_ROUTE)) begin
			// R16: host keeps reserved bits zero
			next_fault_routing_enables = reg_wdata_i & serr_pkg::ROUTE_MASK;
		end else if (reg_wr_i && (reg_addr_i == serr_pkg::ADDR_SETUP)) begin
			next_main_operating_setup = reg_wdata_i;
		end
	end

	// Read data mux; the status word is sampled before its clear takes effect
	always_comb begin
		if (reg_addr_i == serr_pkg::ADDR_FLAGS) begin
			// R10: reserved bits stay zero
			next_rdata = status_word(fault_source_channel, fault_flags, result_ready_flag, unread);
		end else if (reg_addr_i == serr_pkg::ADDR_ROUTE) begin
			next_rdata = fault_routing_enables;
		end else if (reg_addr_i == serr_pkg::ADDR_SETUP) begin
			next_rdata = main_operating_setup;
		end else begin
			// Unmapped index reads zero
			next_rdata = 16'h0000;
		end
		if (!reg_rd_i) begin
			next_rdata = reg_rdata_o;
		end
	end

	// Pin level follows the next flag values so it moves with the status bits
	always_comb begin
		// R17: disable holds pin high
		// Uses the value being written so pin and setup bit change together
		if (next_main_operating_setup[serr_pkg::SU_IRQ_DIS]) begin
			next_irq_n = 1'b1;
		end else begin
			// R18: low while pending
			next_irq_n = !((next_fault_flags != 6'h00) || next_result_ready_flag);
		end
	end

	// State registers
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			fault_flags <= 6'h00;
			fault_source_channel <= 2'h0;
			result_ready_flag <= 1'b0;
			unread <= 4'h0;
			res_err <= 16'h0000;
			fault_routing_enables <= serr_pkg::ROUTE_RESET;
			main_operating_setup <= serr_pkg::SETUP_RESET;
			reg_rdata_o <= 16'h0000;
			irq_pin_n_o <= 1'b1;
		end else begin
			fault_flags <= next_fault_flags;
			fault_source_channel <= next_fault_source_channel;
			result_ready_flag <= next_result_ready_flag;
			unread <= next_unread;
			res_err <= next_res_err;
			fault_routing_enables <= next_fault_routing_enables;
			main_operating_setup <= next_main_operating_setup;
			reg_rdata_o <= next_rdata;
			irq_pin_n_o <= next_irq_n;
		end
	end

	// Copies for other blocks come straight from the flops
	assign result_err_o = res_err;
	assign main_operating_setup_o = main_operating_setup;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	// Sequence of a gated fault arriving with nothing pending
	sequence s_first_fault;
		fault_valid_i && (fault_hit != 6'h00) && (fault_flags == 6'h00);
	endsequence

	a_source_channel: assert property (s_first_fault |=> //R1
		fault_source_channel == $past(fault_ch_i))
		else $error("fault source channel not recorded");
	a_fault_clear: assert property ((status_read && !fault_valid_i) |=> //R2
		(fault_flags == 6'h00) && (reg_rdata_o[13:8] == $past(fault_flags)))
		else $error("status read did not clear faults");
	a_under_set: assert property ((fault_valid_i && fault_type_i[5] //R3
		&& fault_routing_enables[7]) |=> fault_flags[5])
		else $error("under-range flag not set");
	a_over_set: assert property ((fault_valid_i && fault_type_i[4] //R4
		&& fault_routing_enables[6]) |=> fault_flags[4])
		else $error("over-range flag not set");
	a_timeout_set: assert property ((fault_valid_i && fault_type_i[3] //R5
		&& fault_routing_enables[5]) |=> fault_flags[3])
		else $error("timeout flag not set");
	a_amp_high: assert property ((fault_valid_i && fault_type_i[2] //R6
		&& fault_routing_enables[4]) |=> fault_flags[2])
		else $error("amplitude high flag not set");
	a_amp_low: assert property ((fault_valid_i && fault_type_i[1] //R7
		&& fault_routing_enables[3]) |=> fault_flags[1])
		else $error("amplitude low flag not set");
	a_zero_count: assert property ((fault_valid_i && fault_type_i[0] //R8
		&& fault_routing_enables[2]) |=> fault_flags[0])
		else $error("zero count flag not set");
	a_ready_set: assert property ((ready_event_i && fault_routing_enables[0]) //R9
		|=> result_ready_flag)
		else $error("ready flag not set");
	a_reserved_zero: assert property ((reg_rd_i && reg_addr_i == 8'h18) //R10
		|=> (reg_rdata_o[7] == 1'b0) && (reg_rdata_o[5:4] == 2'b00))
		else $error("reserved status bits not zero");
	a_unread_set: assert property ((conv_done_i && conv_ch_i == 2'd0) //R11
		|=> unread[0])
		else $error("unread flag not set");
	// Either amplitude fault lands in the shared field of its own channel
	a_amp_route: assert property ((fault_valid_i //R13
		&& ((fault_type_i[2] && fault_routing_enables[12])
		|| (fault_type_i[1] && fault_routing_enables[11])))
		|=> res_err[{$past(fault_ch_i), 2'b00}])
		else $error("amplitude fault not routed");
	a_gate_off: assert property ((fault_valid_i && fault_routing_enables[7:2] == 6'h00 //R14
		&& fault_flags == 6'h00 && !ready_event_i && !result_ready_flag)
		|=> irq_pin_n_o)
		else $error("masked fault drove pin");
	// Pin is registered from the next setup value, so it tracks the bit in the same cycle
	a_pin_disable: assert property (main_operating_setup[7] |-> irq_pin_n_o) //R17
		else $error("pin low while disabled");
	a_pin_pending: assert property (((fault_flags != 6'h00) && !main_operating_setup[7]) //R18
		|-> !irq_pin_n_o)
		else $error("pin high with pending fault");

	// Routed under-range fault reaches the result field of its own channel
	a_under_route: assert property ((fault_valid_i && fault_type_i[5] //R12
		&& fault_routing_enables[15]) |=> res_err[{$past(fault_ch_i), 2'b11}])
		else $error("under-range not routed to result");
	// Masked kinds must not latch into the fault flags
	a_fault_masked: assert property ((fault_valid_i && (fault_flags == 6'h00) //R14
		&& ((fault_type_i & fault_routing_enables[7:2]) == 6'h00))
		|=> (fault_flags == 6'h00))
		else $error("masked fault latched");
	// Ready with its enable clear is dropped
	a_ready_masked: assert property ((ready_event_i && !fault_routing_enables[0] //R15
		&& !result_ready_flag) |=> !result_ready_flag)
		else $error("masked ready latched");
	// A status read consumes the ready flag
	a_ready_clear: assert property ((status_read && !ready_event_i) //R9
		|=> !result_ready_flag)
		else $error("status read did not clear ready");
	// Reading the source channel result also releases the faults
	a_source_clear: assert property ((src_read && !fault_valid_i) //R2
		|=> (fault_flags == 6'h00))
		else $error("source result read did not clear faults");
	// Reading a channel result drops its unread flag
	a_unread_clear: assert property ((data_rd_i && !conv_done_i) //R11
		|=> !unread[$past(data_rd_ch_i)])
		else $error("unread flag not cleared by result read");
endmodule : serr_status

// *** tb/serr_host.sv ***
`timescale 1ns/100ps
// Host side of the register port, as the serial front end would present it
module serr_host (
	// Clock
	input wire logic clk_sys_i,
	// Register port
	input wire logic [15:0] reg_rdata_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [15:0] reg_wdata_o,
	output logic reg_rd_o
);
	// Idle port: no strobe, an unmapped index
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 16'h0000;
		reg_rd_o = 1'b0;
	end
	// One-cycle write strobe; data held with it
	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		@(posedge clk_sys_i);
		reg_addr_o <= ad;
		reg_wdata_o <= (ad == serr_pkg::ADDR_ROUTE) ? (d & serr_pkg::ROUTE_MASK) : d;
		reg_wr_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		// Bit lines no longer qualified: show a changed pattern
		reg_wdata_o <= ~d;
		@(negedge clk_sys_i);
	endtask : wr
	// Read data lands one cycle after the strobe edge
	task automatic rd(input logic [7:0] ad, output logic [15:0] d);
		@(posedge clk_sys_i);
		reg_addr_o <= ad;
		reg_rd_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b0;
		@(negedge clk_sys_i);
		d = reg_rdata_i;
	endtask : rd
endmodule : serr_host

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	// Engine event strobes and their qualifiers
	logic fv = 1'b0, cd = 1'b0, re = 1'b0, dr = 1'b0;
	logic [1:0] ch = 2'b00;
	logic [5:0] ft = 6'h00;
	// Register port and observed outputs
	logic [7:0] a;
	logic w, r, irq;
	logic [15:0] wd, rdat, rerr, setup, v;
	int fails = 0;
	int comparisons = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	serr_host i_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdat), .reg_addr_o(a),
		.reg_wr_o(w), .reg_wdata_o(wd), .reg_rd_o(r));
	serr_status i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(a),
		.reg_wr_i(w), .reg_wdata_i(wd), .reg_rd_i(r), .reg_rdata_o(rdat),
		.fault_valid_i(fv), .fault_ch_i(ch), .fault_type_i(ft), .conv_done_i(cd),
		.conv_ch_i(ch), .ready_event_i(re), .data_rd_i(dr), .data_rd_ch_i(ch),
		.result_err_o(rerr), .main_operating_setup_o(setup), .irq_pin_n_o(irq));
	// Four-state compare, so an unknown never matches
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdreg(input logic [7:0] ad, input logic [15:0] e);
		i_host.rd(ad, v);
		chk($sformatf("reg %h", ad), e, v);
	endtask : rdreg
	// Event pulse; kind bits are fault, conversion, ready, result read
	task automatic ev(input logic [3:0] k, input logic [1:0] c, input logic [5:0] t);
		@(posedge clk_sys_i);
		{fv, cd, re, dr} <= k;
		ch <= c;
		ft <= t;
		@(posedge clk_sys_i);
		{fv, cd, re, dr} <= 4'h0;
		@(negedge clk_sys_i);
	endtask : ev
	task automatic give_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// Hang guard well beyond the real run
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		fails++;
		give_verdict();
	end
	initial begin
		logic [5:0] t;
		logic [3:0] nib;
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		rdreg(serr_pkg::ADDR_SETUP, 16'h2801);
		chk("setup out", 16'h2801, setup);
		rdreg(serr_pkg::ADDR_ROUTE, 16'h0000);
		rdreg(serr_pkg::ADDR_FLAGS, 16'h0000);
		rdreg(8'h1B, 16'h0000);
		$display("test reset done");
		// Nothing enabled: faults and ready stay silent
		ev(4'h8, 2'd0, 6'h3F);
		ev(4'h2, 2'd0, 6'h00);
		chk("pin masked", 16'h0001, {15'h0, irq});
		chk("result masked", 16'h0000, rerr);
		rdreg(serr_pkg::ADDR_FLAGS, 16'h0000);
		$display("test masked done");
		i_host.wr(serr_pkg::ADDR_ROUTE, 16'hFFFF);
		rdreg(serr_pkg::ADDR_ROUTE, 16'hF8FD);
		// Each fault kind alone, on a rotating channel
		for (int i = 0; i < 6; i++) begin
			t = 6'h01 << i;
			nib = {t[5], t[4], t[3], t[2] | t[1]};
			ev(4'h8, 2'(i), t);
			chk("pin set", 16'h0000, {15'h0, irq});
			chk("result", 16'(nib) << (4 * (i % 4)), rerr);
			rdreg(serr_pkg::ADDR_FLAGS, {2'(i), t, 8'h00});
			chk("pin clear", 16'h0001, {15'h0, irq});
			ev(4'h1, 2'(i), 6'h00);
			chk("result clear", 16'h0000, rerr);
		end
		$display("test kinds done");
		// First source kept; only the source result read clears
		ev(4'h8, 2'd2, 6'h20);
		ev(4'h8, 2'd3, 6'h10);
		ev(4'h1, 2'd3, 6'h00);
		chk("pin other read", 16'h0000, {15'h0, irq});
		chk("result ch2", 16'h0800, rerr);
		rdreg(serr_pkg::ADDR_FLAGS, 16'hB000);
		ev(4'h8, 2'd1, 6'h08);
		ev(4'h1, 2'd1, 6'h00);
		chk("pin source read", 16'h0001, {15'h0, irq});
		// Source field keeps the last recorded channel after the clear
		rdreg(serr_pkg::ADDR_FLAGS, 16'h4000);
		ev(4'h1, 2'd2, 6'h00);
		$display("test source done");
		// Results on all channels, then ready
		for (int c = 0; c < 4; c++) ev(4'h4, 2'(c), 6'h00);
		ev(4'h2, 2'd0, 6'h00);
		chk("pin ready", 16'h0000, {15'h0, irq});
		rdreg(serr_pkg::ADDR_FLAGS, 16'h404F);
		rdreg(serr_pkg::ADDR_FLAGS, 16'h400F);
		ev(4'h1, 2'd0, 6'h00);
		rdreg(serr_pkg::ADDR_FLAGS, 16'h4007);
		for (int c = 1; c < 4; c++) ev(4'h1, 2'(c), 6'h00);
		rdreg(serr_pkg::ADDR_FLAGS, 16'h4000);
		$display("test ready done");
		// Pin disabled in setup: status still latches
		i_host.wr(serr_pkg::ADDR_SETUP, 16'h2881);
		chk("setup out", 16'h2881, setup);
		ev(4'h8, 2'd0, 6'h01);
		chk("pin disabled", 16'h0001, {15'h0, irq});
		rdreg(serr_pkg::ADDR_FLAGS, 16'h0100);
		$display("test disable done");
		give_verdict();
	end
endmodule : tb
